/* File: bench/pulse_load_model.sv */
`timescale 1ns/1ps
module pulse_load_model (
	// clock
	input  wire logic       mclk_i,
	// timer output seen by the load
	input  wire logic       load_pin_i,
	// pulse source toward the timer
	output logic [1:0]      pulse_o,
	// measured waveform, in clock cycles
	output int              rises_o,
	output int              falls_o,
	output int              high_len_o,
	output int              period_o
);
	int   now;
	int   rise_at;
	logic last;

	initial
	begin
		pulse_o = 2'h0;
		now = 0;
		rise_at = 0;
		last = 1'b0;
		rises_o = 0;
		falls_o = 0;
		high_len_o = 0;
		period_o = 0;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs update by nba so readers at the same edge never race
	always @(posedge mclk_i)
	begin
		now = now + 1;
		if (load_pin_i === 1'b1 && last === 1'b0)
		begin
			period_o <= now - rise_at;
			rise_at = now;
			rises_o <= rises_o + 1;
		end
		if (load_pin_i === 1'b0 && last === 1'b1)
		begin
			high_len_o <= now - rise_at;
			falls_o <= falls_o + 1;
		end
		last = load_pin_i;
	end

	////////////////////////////////////////////////////////////////////////
	// the idle gap covers the timer's input synchroniser latency
	task automatic send_pulse(input int ch, input int hi);
		@(posedge mclk_i);
		pulse_o[ch] <= 1'b1;
		repeat (hi) @(posedge mclk_i);
		pulse_o[ch] <= 1'b0;
		repeat (20) @(posedge mclk_i);
	endtask
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import pwm_pwc_pkg::*;
	logic        mclk_i;
	logic        resetn_i;
	apb_req_s    req;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  pulse;
	logic        pin;
	logic        oe;
	logic [31:0] q;
	logic        err;
	int          rises;
	int          falls;
	int          high_len;
	int          period;
	int          failures;
	int          num_checks;

	pwm_pwc_timer uut (
		.mclk_i             (mclk_i),
		.resetn_i           (resetn_i),
		.apb_req_i          (req),
		.prdata_o           (prdata),
		.pready_o           (pready),
		.pslverr_o          (pslverr),
		.pulse_in_i         (pulse),
		.lower_output_pin_o (pin),
		.upper_output_pin_o (),
		.lower_output_en_o  (oe),
		.upper_output_en_o  ()
	);

	pulse_load_model src (
		.mclk_i     (mclk_i),
		.load_pin_i (pin),
		.pulse_o    (pulse),
		.rises_o    (rises),
		.falls_o    (falls),
		.high_len_o (high_len),
		.period_o   (period)
	);

	always #5 mclk_i = ~mclk_i;

	////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask

	// entered just after a rising edge; holds the request until pready
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge mclk_i);
		req.penable <= 1'b1;
		do
			@(posedge mclk_i);
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		req <= '0;
		// idle edge: the next setup never shares this time step
		@(posedge mclk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic wait_falls(input int target);
		int t;
		t = 0;
		while (falls < target && t < 3000)
		begin
			@(posedge mclk_i);
			t++;
		end
		if (falls < target)
			check_val("falls reached", 32'(target), 32'(falls));
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic test_regs;
		for (int k = 0; k < 7; k++)
		begin
			rd(8'(k * 4));
			check_val("reset value", 32'(REG_RESET), q);
		end
		rd(8'h1c);
		check_val("unmapped error", 32'h1, 32'(err));
		check_val("unmapped data", 32'h0, q);
		wr(OFS_LOWER_FUNC, 32'h5b);
		rd(OFS_LOWER_FUNC);
		check_val("function readback", 32'h5b, q);
		wr(OFS_LOWER_RUN, 32'h01);
		check_val("output enable", 32'h1, 32'(oe));
	endtask

	task automatic test_fixed;
		int   b;
		logic lvl;
		wr(OFS_LOWER_DATA, 32'h10);
		wr(OFS_LOWER_FUNC, 32'(FN_FIXED));
		b = falls;
		wr(OFS_LOWER_RUN, 32'h81);
		wait_falls(b + 1);
		check_val("first high", 32'd15, high_len);
		wait_falls(b + 3);
		check_val("high width", 32'd16, high_len);
		check_val("fixed period", 32'(FULL8), period);
		rd(OFS_LOWER_RUN);
		check_val("fixed match flag", 32'h0, 32'(q[RS_IF]));
		wr(OFS_LOWER_RUN, 32'h01);
		lvl = pin;
		b = rises;
		repeat (300) @(posedge mclk_i);
		check_val("held level", 32'(lvl), 32'(pin));
		check_val("held edges", b, rises);
	endtask

	task automatic test_var;
		int h1;
		int p1;
		int b;
		wr(OFS_PAIR_MODE, 32'h10);
		wr(OFS_UPPER_FUNC, 32'(FN_VAR));
		wr(OFS_LOWER_FUNC, 32'(FN_VAR));
		wr(OFS_UPPER_DATA, 32'h40);
		wr(OFS_LOWER_DATA, 32'h10);
		b = falls;
		wr(OFS_LOWER_RUN, 32'h83);
		rd(OFS_PAIR_MODE);
		check_val("join bit", 32'h0, 32'(q[PM_JOIN]));
		check_val("start level", 32'h0, 32'(pin));
		wait_falls(b + 3);
		h1 = high_len;
		p1 = period;
		wr(OFS_LOWER_DATA, 32'h20);
		wait_falls(falls + 3);
		check_val("var period", p1, period);
		check_val("low width step", 32'd16, h1 - high_len);
		rd(OFS_LOWER_RUN);
		check_val("lower match flag", 32'h1, 32'(q[RS_IF]));
		rd(OFS_UPPER_RUN);
		check_val("upper match flag", 32'h1, 32'(q[RS_IF]));
		wr(OFS_LOWER_DATA, 32'h50);
		repeat (200) @(posedge mclk_i);
		b = rises;
		repeat (300) @(posedge mclk_i);
		check_val("no high edges", b, rises);
		check_val("stays low", 32'h0, 32'(pin));
		wr(OFS_LOWER_RUN, 32'h00);
	endtask

	task automatic test_pwc;
		logic [31:0] v1;
		wr(OFS_LOWER_FUNC, 32'(FN_PWC_HIGH));
		wr(OFS_LOWER_RUN, 32'h83);
		repeat (4) @(posedge mclk_i);
		check_val("initial level", 32'h1, 32'(pin));
		src.send_pulse(0, 40);
		rd(OFS_LOWER_RUN);
		check_val("done and held", 32'h3, 32'(q[RS_IR:RS_BF]));
		src.send_pulse(0, 60);
		rd(OFS_LOWER_DATA);
		v1 = q;
		rd(OFS_LOWER_RUN);
		check_val("held cleared", 32'h0, 32'(q[RS_BF]));
		src.send_pulse(0, 60);
		rd(OFS_LOWER_DATA);
		check_val("width delta", 32'd20, q - v1);
		src.send_pulse(0, 300);
		rd(OFS_LOWER_RUN);
		check_val("overflow flag", 32'h1, 32'(q[RS_IF]));
		check_val("overflow toggle", 32'h0, 32'(pin));
	endtask

	task automatic test_hcyc;
		logic [31:0] v1;
		wr(OFS_LOWER_RUN, 32'h00);
		wr(OFS_LOWER_FUNC, 32'(FN_PWC_HCYC));
		rd(OFS_LOWER_DATA);
		wr(OFS_LOWER_RUN, 32'h81);
		src.send_pulse(0, 40);
		rd(OFS_LOWER_DATA);
		v1 = q;
		// cycle result stored here sets held; next high still lands
		src.send_pulse(0, 40);
		src.send_pulse(0, 50);
		rd(OFS_LOWER_DATA);
		check_val("high while held", 32'd10, q - v1);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		mclk_i = 1'b0;
		resetn_i = 1'b0;
		req = '0;
		failures = 0;
		num_checks = 0;
		repeat (12) @(posedge mclk_i);
		resetn_i <= 1'b1;
		@(posedge mclk_i);
		test_regs();
		test_fixed();
		test_var();
		test_pwc();
		test_hcyc();
		summarize();
	end

	// the whole sequence needs a few thousand cycles
	initial
	begin
		#500000;
		failures++;
		summarize();
	end
endmodule

/* File: verilog/pwm_pwc_pkg.sv */
package pwm_pwc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CLK_W  = 3;
	localparam int FN_W   = 4;

	// register byte addresses
	localparam logic [ADDR_W-1:0] OFS_LOWER_FUNC = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_UPPER_FUNC = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_LOWER_RUN  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_UPPER_RUN  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_PAIR_MODE  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_LOWER_DATA = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_UPPER_DATA = 8'h18;

	// function control fields
	localparam int FC_IRQ_GATE = 7;
	localparam int FC_CLK_LSB  = 4;
	localparam int FC_FN_LSB   = 0;
	// run/status fields
	localparam int RS_RUN   = 7;
	localparam int RS_PAUSE = 6;
	localparam int RS_IE    = 5;
	localparam int RS_IR    = 4;
	localparam int RS_BF    = 3;
	localparam int RS_IF    = 2;
	localparam int RS_SO    = 1;
	localparam int RS_OE    = 0;
	localparam logic [7:0] RS_WMASK   = 8'he3;
	localparam logic [7:0] RS_CLRMASK = 8'h14;
	localparam logic [7:0] RS_BFMASK  = 8'h08;
	// pair mode fields
	localparam int PM_UPPER_OUT = 7;
	localparam int PM_LOWER_OUT = 6;
	localparam int PM_SRC       = 5;
	localparam int PM_JOIN      = 4;
	localparam logic [7:0] PM_WMASK = 8'h3f;

	localparam logic [7:0] REG_RESET = 8'h00;

	// function select codes
	localparam logic [FN_W-1:0] FN_FIXED    = 4'h3;
	localparam logic [FN_W-1:0] FN_VAR      = 4'h4;
	localparam logic [FN_W-1:0] FN_PWC_HIGH = 4'h8;
	localparam logic [FN_W-1:0] FN_PWC_HCYC = 4'h9;
	localparam logic [FN_W-1:0] FN_PWC_LOW  = 4'ha;
	localparam logic [FN_W-1:0] FN_PWC_CYC  = 4'hb;
	localparam logic [1:0]      FN_PWC_TOP  = 2'h2;

	localparam logic [15:0] FULL8  = 16'h00ff;
	localparam logic [15:0] FULL16 = 16'hffff;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] ONE16  = 16'h0001;

	typedef enum logic [1:0] {PWC_WAIT, PWC_MEASURE, PWC_SECOND} pwc_state_e;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] latch;
		logic        out;
		pwc_state_e  st;
		logic        if_set;
		logic        ir_set;
		logic        cap;
		logic [15:0] cap_val;
	} chan_s;
endpackage

/* File: verilog/pwm_pwc_timer.sv */
// How it works
// - fixed-cycle PWM: fixed period, programmable high
// - fixed period is 255 ticks, 65535 when joined
// - high width comes from data register
// - fixed PWM never sets match flag
// - fixed period starts high, ignores initial level
// - compare latch reloads at start and match
// - stopped timer holds its output level
// - first fixed high pulse one clock short
// - variable PWM: upper sets period, lower low
// - variable PWM run clears the join bit
// - variable PWM first period starts low
// - each counter flags its own match
// - low width above period: never high
// - new data takes effect after match
// - measurement restarts from zero on start edge
// - end edge stores count, sets both flags
// - data read clears result-held flag
// - held result blocks new stores, except high-and-cycle high
// - high-and-cycle mode stores high always, cycle only if not held
// - measurement overflow flags and toggles output
// - measurement output starts at initial level
`timescale 1ns/1ps
module pwm_pwc_timer (
	// clock and reset
	input  wire logic                         mclk_i,
	input  wire logic                         resetn_i,
	// register bus
	input  wire pwm_pwc_pkg::apb_req_s        apb_req_i,
	output logic [pwm_pwc_pkg::DATA_W-1:0]    prdata_o,
	output logic                              pready_o,
	output logic                              pslverr_o,
	// external pulse inputs, lower then upper
	input  wire logic [1:0]                   pulse_in_i,
	// timer outputs
	output logic                              lower_output_pin_o,
	output logic                              upper_output_pin_o,
	output logic                              lower_output_en_o,
	output logic                              upper_output_en_o
);
	import pwm_pwc_pkg::*;

	function automatic logic is_pwc(input logic [FN_W-1:0] fn);
		is_pwc = (fn[FN_W-1 -: 2] == FN_PWC_TOP);
	endfunction

	// one channel of fixed PWM or pulse measurement
	function automatic chan_s chan_step(
		input logic [FN_W-1:0] fn,
		input logic            start,
		input logic            run,
		input logic            tick,
		input logic            rise,
		input logic            fall,
		input logic            bf,
		input logic            so,
		input logic [15:0]     full,
		input logic [15:0]     data,
		input chan_s           cur
	);
		chan_s r;
		logic  sedge;
		logic  eedge;
		r = cur;
		r.if_set = 1'b0;
		r.ir_set = 1'b0;
		r.cap = 1'b0;
		r.cap_val = cur.cnt;
		sedge = (fn == FN_PWC_LOW) ? fall : rise;
		eedge = (fn == FN_PWC_HIGH || fn == FN_PWC_HCYC) ? fall : rise;
		if (start)
		begin
			r.latch = data;
			r.st = PWC_WAIT;
			r.cnt = ZERO16;
			// start high, one clock already counted
			if (fn == FN_FIXED)
			begin
				r.out = 1'b1;
				r.cnt = ONE16;
			end
			else if (is_pwc(fn))
				r.out = so;
		end
		else if (run && fn == FN_FIXED)
		begin
			if (tick)
			begin
				r.cnt = (cur.cnt == full - ONE16) ? ZERO16 : cur.cnt + ONE16;
				if (r.cnt == cur.latch)
				begin
					r.out = 1'b0;
					r.latch = data;
				end
				else if (r.cnt == ZERO16)
					r.out = 1'b1;
			end
		end
		else if (run && is_pwc(fn))
		begin
			if (tick && cur.st != PWC_WAIT)
			begin
				r.cnt = (cur.cnt == full) ? ZERO16 : cur.cnt + ONE16;
				if (cur.cnt == full)
				begin
					r.if_set = 1'b1;
					r.out = ~cur.out;
				end
			end
			unique case (cur.st)
				PWC_WAIT:
				if (sedge)
				begin
					r.cnt = ZERO16;
					r.st = PWC_MEASURE;
				end
				PWC_MEASURE:
				if (eedge)
				begin
					r.cap = !bf || fn == FN_PWC_HCYC;
					r.ir_set = r.cap;
					if (fn == FN_PWC_CYC)
						r.cnt = ZERO16;
					else if (fn == FN_PWC_HCYC)
						r.st = PWC_SECOND;
					else
						r.st = PWC_WAIT;
				end
				PWC_SECOND:
				if (rise)
				begin
					r.cap = !bf;
					r.ir_set = !bf;
					r.cnt = ZERO16;
					r.st = PWC_MEASURE;
				end
				default:
					r.st = PWC_WAIT;
			endcase
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// counters

	logic [7:0]  cnt_reg [2];
	logic [7:0]  cnt_next [2];
	logic [7:0]  latch_reg [2];
	logic [7:0]  latch_next [2];
	logic        out_reg [2];
	logic        out_next [2];
	pwc_state_e  st_reg [2];
	pwc_state_e  st_next [2];
	logic [1:0]  run_d_reg;
	logic [1:0]  run_d_next;
	logic [6:0]  pre_reg;
	logic [6:0]  pre_next;
	logic [1:0]  s1_reg;
	logic [1:0]  s2_reg;
	logic [1:0]  s3_reg;
	logic [6:0]  mask [2];
	logic [1:0]  tick;
	logic [1:0]  run_bit;
	logic [1:0]  start;
	logic [1:0]  rise;
	logic [1:0]  fall;
	logic        joined;
	logic        var_mode;
	logic        vrun;
	logic        vstart;
	logic [15:0] full0;
	logic [15:0] data0;
	chan_s       cur [2];
	chan_s       nxt [2];

	logic [7:0]  fc_reg [2];
	logic [7:0]  rs_reg [2];
	logic [7:0]  pm_reg;
	logic [7:0]  data_reg [2];

	always_comb
	begin
		pre_next = pre_reg + 7'h01;
		joined = pm_reg[PM_JOIN];
		var_mode = (fc_reg[0][FC_FN_LSB +: FN_W] == FN_VAR) && !joined;
		for (int i = 0; i < 2; i++)
		begin
			mask[i] = 7'((8'h01 << fc_reg[i][FC_CLK_LSB +: CLK_W]) - 8'h01);
			// pause freezes the count but keeps the output
			tick[i] = ((pre_reg & mask[i]) == mask[i])
				&& !rs_reg[i][RS_PAUSE];
			run_bit[i] = rs_reg[i][RS_RUN];
			start[i] = run_bit[i] && !run_d_reg[i];
			rise[i] = s2_reg[i] && !s3_reg[i];
			fall[i] = !s2_reg[i] && s3_reg[i];
			cur[i] = '0;
			cur[i].cnt = {8'h00, cnt_reg[i]};
			cur[i].latch = {8'h00, latch_reg[i]};
			cur[i].out = out_reg[i];
			cur[i].st = st_reg[i];
		end
		if (joined)
		begin
			cur[0].cnt = {cnt_reg[1], cnt_reg[0]};
			cur[0].latch = {latch_reg[1], latch_reg[0]};
		end
		full0 = joined ? FULL16 : FULL8;
		data0 = joined ? {data_reg[1], data_reg[0]} : {8'h00, data_reg[0]};
		vrun = run_bit[0] || run_bit[1];
		vstart = vrun && run_d_reg == 2'h0;
		nxt[0] = chan_step(fc_reg[0][FC_FN_LSB +: FN_W], start[0],
			run_bit[0], tick[0], rise[0], fall[0], rs_reg[0][RS_BF],
			rs_reg[0][RS_SO], full0, data0, cur[0]);
		nxt[1] = chan_step(fc_reg[1][FC_FN_LSB +: FN_W], start[1] && !joined,
			run_bit[1] && !joined, tick[1], rise[1], fall[1],
			rs_reg[1][RS_BF], rs_reg[1][RS_SO], FULL8,
			{8'h00, data_reg[1]}, cur[1]);
		// both counters, output on lower pin
		if (var_mode)
		begin
			nxt[0] = cur[0];
			nxt[1] = cur[1];
			if (vstart)
			begin
				nxt[0].cnt = ZERO16;
				nxt[1].cnt = ZERO16;
				nxt[0].latch = data0;
				nxt[1].latch = {8'h00, data_reg[1]};
				nxt[0].out = 1'b0;
				nxt[0].st = PWC_MEASURE;
			end
			else if (vrun)
			begin
				if (tick[0] && cur[0].st == PWC_MEASURE)
				begin
					if (cur[0].cnt == cur[0].latch)
					begin
						nxt[0].out = 1'b1;
						nxt[0].if_set = 1'b1;
						nxt[0].latch = data0;
						nxt[0].st = PWC_WAIT;
					end
					else
						nxt[0].cnt = cur[0].cnt + ONE16;
				end
				// period end wins over low match
				if (tick[1])
				begin
					if (cur[1].cnt == cur[1].latch)
					begin
						nxt[1].cnt = ZERO16;
						nxt[1].if_set = 1'b1;
						nxt[1].latch = {8'h00, data_reg[1]};
						nxt[0].cnt = ZERO16;
						nxt[0].out = 1'b0;
						nxt[0].st = PWC_MEASURE;
					end
					else
						nxt[1].cnt = cur[1].cnt + ONE16;
				end
			end
		end
		for (int i = 0; i < 2; i++)
		begin
			// no run, nothing changes the output
			cnt_next[i] = nxt[i].cnt[7:0];
			latch_next[i] = nxt[i].latch[7:0];
			out_next[i] = nxt[i].out;
			st_next[i] = nxt[i].st;
		end
		if (joined)
		begin
			cnt_next[1] = nxt[0].cnt[15:8];
			latch_next[1] = nxt[0].latch[15:8];
		end
		run_d_next = run_bit;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			for (int i = 0; i < 2; i++)
			begin
				cnt_reg[i] <= REG_RESET;
				latch_reg[i] <= REG_RESET;
				out_reg[i] <= 1'b0;
				st_reg[i] <= PWC_WAIT;
			end
			run_d_reg <= 2'h0;
			pre_reg <= 7'h00;
			s1_reg <= 2'h0;
			s2_reg <= 2'h0;
			s3_reg <= 2'h0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			latch_reg <= latch_next;
			out_reg <= out_next;
			st_reg <= st_next;
			run_d_reg <= run_d_next;
			pre_reg <= pre_next;
			s1_reg <= pulse_in_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	assign lower_output_pin_o = out_reg[0];
	assign upper_output_pin_o = out_reg[1];
	assign lower_output_en_o = rs_reg[0][RS_OE];
	assign upper_output_en_o = rs_reg[1][RS_OE];

	////////////////////////////////////////////////////////////////////////
	// register bus

	logic [7:0]        fc_next [2];
	logic [7:0]        rs_next [2];
	logic [7:0]        pm_next;
	logic [7:0]        data_next [2];
	logic [DATA_W-1:0] prdata_reg;
	logic [DATA_W-1:0] prdata_next;
	logic [7:0]        wdat;
	logic [7:0]        rmux;
	logic              hit;
	logic              wr_en;
	logic              rd_en;

	always_comb
	begin
		fc_next = fc_reg;
		rs_next = rs_reg;
		pm_next = pm_reg;
		data_next = data_reg;
		prdata_next = prdata_reg;
		wdat = apb_req_i.pwdata[7:0];
		wr_en = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
		rd_en = apb_req_i.psel && apb_req_i.penable && !apb_req_i.pwrite;
		hit = 1'b1;
		rmux = REG_RESET;
		case (apb_req_i.paddr)
			OFS_LOWER_FUNC: rmux = fc_reg[0];
			OFS_UPPER_FUNC: rmux = fc_reg[1];
			OFS_LOWER_RUN:  rmux = rs_reg[0];
			OFS_UPPER_RUN:  rmux = rs_reg[1];
			OFS_PAIR_MODE:  rmux = pm_reg | ({7'h00, out_reg[1]} << PM_UPPER_OUT)
				| ({7'h00, out_reg[0]} << PM_LOWER_OUT);
			OFS_LOWER_DATA: rmux = data_reg[0];
			OFS_UPPER_DATA: rmux = data_reg[1];
			default:        hit = 1'b0;
		endcase
		// read data is fetched in the setup cycle so the answer is a flop
		if (apb_req_i.psel && !apb_req_i.penable)
			prdata_next = {24'h000000, rmux};
		if (wr_en)
		begin
			// IR and IF flag bits clear on a written zero only; writes leave the held flag BF unchanged
			case (apb_req_i.paddr)
				OFS_LOWER_FUNC: fc_next[0] = wdat;
				OFS_UPPER_FUNC: fc_next[1] = wdat;
				OFS_LOWER_RUN:  rs_next[0] = (wdat & RS_WMASK)
					| (rs_reg[0] & RS_BFMASK) | (rs_reg[0] & wdat & RS_CLRMASK);
				OFS_UPPER_RUN:  rs_next[1] = (wdat & RS_WMASK)
					| (rs_reg[1] & RS_BFMASK) | (rs_reg[1] & wdat & RS_CLRMASK);
				OFS_PAIR_MODE:  pm_next = wdat & PM_WMASK;
				OFS_LOWER_DATA: data_next[0] = wdat;
				OFS_UPPER_DATA: data_next[1] = wdat;
				default:        pm_next = pm_reg;
			endcase
		end
		// data read clears the held flag
		if (rd_en && apb_req_i.paddr == OFS_LOWER_DATA)
			rs_next[0][RS_BF] = 1'b0;
		if (rd_en && apb_req_i.paddr == OFS_UPPER_DATA)
			rs_next[1][RS_BF] = 1'b0;
		if (fc_next[0][FC_FN_LSB +: FN_W] == FN_VAR
			&& (rs_next[0][RS_RUN] || rs_next[1][RS_RUN]))
			pm_next[PM_JOIN] = 1'b0;
		// hardware events win over a clear in the same cycle
		for (int i = 0; i < 2; i++)
		begin
			if (nxt[i].if_set)
				rs_next[i][RS_IF] = 1'b1;
			if (nxt[i].cap)
			begin
				rs_next[i][RS_IR] = 1'b1;
				rs_next[i][RS_BF] = 1'b1;
				data_next[i] = nxt[i].cap_val[7:0];
			end
		end
		if (nxt[0].cap && joined)
			data_next[1] = nxt[0].cap_val[15:8];
	end

	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			for (int i = 0; i < 2; i++)
			begin
				fc_reg[i] <= REG_RESET;
				rs_reg[i] <= REG_RESET;
				data_reg[i] <= REG_RESET;
			end
			pm_reg <= REG_RESET;
			prdata_reg <= '0;
		end
		else
		begin
			fc_reg <= fc_next;
			rs_reg <= rs_next;
			data_reg <= data_next;
			pm_reg <= pm_next;
			prdata_reg <= prdata_next;
		end
	end

	assign prdata_o = prdata_reg;
	assign pready_o = 1'b1;
	assign pslverr_o = apb_req_i.psel && apb_req_i.penable && !hit;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	a_fix_no_flag: assert property (
		fc_reg[0][FC_FN_LSB +: FN_W] == FN_FIXED && run_bit[0]
		|=> !$rose(rs_reg[0][RS_IF]) || fc_reg[0][FC_FN_LSB +: FN_W] != FN_FIXED)
		else $error("fixed pwm set the match flag");
	a_fix_start_high: assert property (
		start[0] && !var_mode && fc_reg[0][FC_FN_LSB +: FN_W] == FN_FIXED
		|=> out_reg[0] ##1 out_reg[0] || cnt_reg[0] == latch_reg[0])
		else $error("fixed pwm did not start high");
	a_fix_first_short: assert property (
		start[0] && !joined && fc_reg[0][FC_FN_LSB +: FN_W] == FN_FIXED
		|=> cnt_reg[0] == 8'h01)
		else $error("first fixed period not shortened");
	a_stop_hold_out: assert property (
		!run_bit[0] && !run_bit[1] |=> $stable(out_reg[0]) && $stable(out_reg[1]))
		else $error("output moved while stopped");
	a_var_join_off: assert property (
		wr_en && apb_req_i.paddr == OFS_LOWER_RUN && wdat[RS_RUN]
		&& fc_reg[0][FC_FN_LSB +: FN_W] == FN_VAR
		|=> !pm_reg[PM_JOIN])
		else $error("join bit left set in variable pwm");
	a_var_start_low: assert property (
		var_mode && vstart |=> !out_reg[0] && cnt_reg[1] == 8'h00)
		else $error("variable pwm did not start low");
	a_var_period_flag: assert property (
		var_mode && vrun && !vstart && tick[1] && cnt_reg[1] == latch_reg[1]
		|=> rs_reg[1][RS_IF] && cnt_reg[1] == 8'h00 && !out_reg[0])
		else $error("period match not flagged");
	a_read_clears_bf: assert property (
		rd_en && apb_req_i.paddr == OFS_LOWER_DATA && !nxt[0].cap
		|=> !rs_reg[0][RS_BF])
		else $error("data read left held flag set");
	a_bf_keeps_data: assert property (
		rs_reg[0][RS_BF] && !joined
		&& fc_reg[0][FC_FN_LSB +: FN_W] != FN_PWC_HCYC
		&& !(wr_en && apb_req_i.paddr == OFS_LOWER_DATA)
		|=> $stable(data_reg[0]))
		else $error("held result overwritten");
	a_pwc_restart: assert property (
		run_bit[0] && !start[0] && !var_mode && st_reg[0] == PWC_WAIT
		&& fc_reg[0][FC_FN_LSB +: FN_W] == FN_PWC_HIGH && rise[0]
		|=> cnt_reg[0] == 8'h00 && st_reg[0] == PWC_MEASURE)
		else $error("measurement did not restart at zero");
	a_pwc_level: assert property (
		start[0] && !var_mode && is_pwc(fc_reg[0][FC_FN_LSB +: FN_W])
		|=> out_reg[0] == $past(rs_reg[0][RS_SO]))
		else $error("measurement output not at initial level");
endmodule
